/* File: src/cmpb_defs.svh */
// Contract
// - Interrupt flag sets when any synchronized comparator output differs from last read value.
// - Shared status holds events of comparators 1, 2, 3 at bits 8, 9, 10.
// - Software writing one to flag or event bits raises an interrupt.
// - Flag and event bits stay set until software clears them.
// - In sleep an enabled comparator keeps working and its interrupt wakes the device.
// - Waking from sleep leaves comparator control registers unchanged.
// - Idle-stop bit 15 set suppresses comparator interrupts while idle.
// - Reset clears comparator control registers, turning all comparators off.
// - Reference control bit 7 enables the ladder.
// - Reference control bit 6 drives ladder onto its pin, overriding port direction.
// - Reference control bit 10 picks external positive reference or ladder output.
// - Reference control bit 4 picks supply rails or external reference pins for ladder.
// - Bits 3 to 0 pick one of 16 ladder taps.
// - Range bit 5 picks coarse 1/24 steps or fine quarter-offset 1/32 steps.
// - Reset clears ladder enable, pin drive, range and tap.
// - Wake from sleep leaves reference control unchanged.
// - All registers read zero after reset; unimplemented bits read zero.
// - Reference generator works regardless of comparator enables.
// - Set event bit blocks further events until cleared; rearm one cycle later.
// - Status mirrors comparator outputs and events read-only.
// - Disabled comparator makes no trigger or interrupt.
`ifndef CMPB_DEFS_SVH
`define CMPB_DEFS_SVH
// ----------------------------------------
// Register byte addresses
// ----------------------------------------
`define CMPB_OFS_STAT 12'h000
`define CMPB_OFS_CON1 12'h004
`define CMPB_OFS_CON2 12'h008
`define CMPB_OFS_CON3 12'h00c
`define CMPB_OFS_REF 12'h010
`define CMPB_OFS_IRQF 12'h014
// ----------------------------------------
// Field positions
// ----------------------------------------
`define CMPB_STAT_IDLE 15
`define CMPB_STAT_EVT_LO 8
`define CMPB_CON_EN 15
`define CMPB_CON_POL 13
`define CMPB_CON_EVT 9
`define CMPB_CON_OUT 8
`define CMPB_CON_EVPOL_HI 7
`define CMPB_CON_EVPOL_LO 6
`define CMPB_REF_SRC 10
`define CMPB_REF_EN 7
`define CMPB_REF_OE 6
`define CMPB_REF_RNG 5
`define CMPB_REF_SS 4
// ----------------------------------------
// Writable masks and reset values
// ----------------------------------------
`define CMPB_CON_WMASK 16'hf0d3
`define CMPB_REF_WMASK 16'h07ff
`define CMPB_RST_VAL 16'h0000
`endif

/* File: src/cmpb_pkg.sv */
package cmpb_pkg;
  // Ladder settings seen by the analog side
  typedef struct packed {
    logic enable;
    logic pin_drive;
    logic source_pick;
    logic supply_pick;
    logic range;
    logic [3:0] tap;
    logic [1:0] bandgap_pick;
  } cmpb_ladder_t;
  // Per comparator analog controls
  typedef struct packed {
    logic enable;
    logic out_en;
    logic low_power;
    logic ref_pick;
    logic [1:0] chan;
  } cmpb_ana_t;
  typedef enum logic [1:0] {
    CMPB_APB_IDLE = 2'b00,
    CMPB_APB_ACC = 2'b01
  } cmpb_apb_t;
endpackage

/* File: src/cmpb_sync.sv */
`timescale 1ns/1ps
// Two-stage synchroniser per comparator output
module cmpb_sync #(
  parameter int WIDTH = 3
) (
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic CLK_EN,
  input wire logic [WIDTH-1:0] D,
  output logic [WIDTH-1:0] Q
);
  typedef struct packed {
    logic [WIDTH-1:0] s1;
    logic [WIDTH-1:0] s2;
  } cmpb_sync_st_t;
  cmpb_sync_st_t st_r;
  cmpb_sync_st_t st_nxt;
  // First stage read only by second stage
  always_comb
  begin
    st_nxt = st_r;
    st_nxt.s1 = D;
    st_nxt.s2 = st_r.s1;
  end
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
      st_r <= '0;
    else if (CLK_EN)
      st_r <= st_nxt;
  end
  assign Q = st_r.s2;
endmodule // cmpb_sync

/* File: src/cmpb_top.sv */
`timescale 1ns/1ps
`include "cmpb_defs.svh"
module cmpb_top #(
  parameter int NCMP = 3
) (
  input wire logic SYS_CLK,
  input wire logic SYS_RST,
  input wire logic CLK_EN,
  input wire logic PSEL,
  input wire logic PENABLE,
  input wire logic PWRITE,
  input wire logic [11:0] PADDR,
  input wire logic [31:0] PWDATA,
  output logic [31:0] PRDATA,
  output logic PREADY,
  output logic PSLVERR,
  input wire logic [NCMP-1:0] CMP_RAW,
  input wire logic IDLE_MODE,
  input wire logic SLEEP_MODE,
  input wire logic IRQ_ENABLE,
  output logic COMPARATOR_IRQ_FLAG,
  output logic IRQ_REQ,
  output logic WAKE_REQ,
  output logic [NCMP-1:0] CMP_OUT,
  output cmpb_pkg::cmpb_ladder_t LADDER,
  output cmpb_pkg::cmpb_ana_t [NCMP-1:0] CMP_ANA
);
  import cmpb_pkg::*;

  // ----------------------------------------
  // State
  // ----------------------------------------
  typedef struct packed {
    logic [NCMP-1:0][15:0] cmp_enable;
    logic [15:0] refc;
    logic idle_stop;
    logic irq_flag;
    logic [NCMP-1:0] snap;
    logic [NCMP-1:0] prev;
    logic [NCMP-1:0] arm_hold;
    logic [31:0] rdata;
    logic irq;
    logic wake;
  } cmpb_st_t;
  cmpb_st_t st_r;
  cmpb_st_t st_nxt;

  logic [NCMP-1:0] sync_out;
  logic [NCMP-1:0] cmp_eff;
  logic [NCMP-1:0] evt_hit;
  logic [NCMP-1:0] evt_bits;
  logic [NCMP-1:0] en_bits;
  logic wr_acc;
  logic rd_acc;
  logic hit;
  logic [15:0] stat_word;

  cmpb_sync #(
    .WIDTH(NCMP)
  ) u_sync (
    .SYS_CLK(SYS_CLK),
    .SYS_RST(SYS_RST),
    .CLK_EN(CLK_EN),
    .D(CMP_RAW),
    .Q(sync_out)
  );

  // ----------------------------------------
  // Per comparator event detection
  // ----------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NCMP; gi++)
    begin : g_cmp
      logic [1:0] evpol;
      logic rise;
      logic fall;
      assign en_bits[gi] = st_r.cmp_enable[gi][`CMPB_CON_EN];
      assign evt_bits[gi] = st_r.cmp_enable[gi][`CMPB_CON_EVT];
      assign evpol = st_r.cmp_enable[gi][`CMPB_CON_EVPOL_HI:`CMPB_CON_EVPOL_LO];
      // Polarity applied after synchroniser
      assign cmp_eff[gi] = en_bits[gi] & (sync_out[gi] ^ st_r.cmp_enable[gi][`CMPB_CON_POL]);
      assign rise = cmp_eff[gi] & ~st_r.prev[gi];
      assign fall = ~cmp_eff[gi] & st_r.prev[gi];
      // Blocked while disabled, event pending or rearming
      assign evt_hit[gi] = en_bits[gi] & ~evt_bits[gi] & ~st_r.arm_hold[gi] &
        ((evpol == 2'b01 & rise) | (evpol == 2'b10 & fall) | (evpol == 2'b11 & (rise | fall)));
    end
  endgenerate

  // ----------------------------------------
  // Bus decode
  // ----------------------------------------
  assign wr_acc = PSEL & PENABLE & PWRITE;
  assign rd_acc = PSEL & PENABLE & ~PWRITE;
  assign hit = (PADDR == `CMPB_OFS_STAT) | (PADDR == `CMPB_OFS_CON1) |
    (PADDR == `CMPB_OFS_CON2) | (PADDR == `CMPB_OFS_CON3) |
    (PADDR == `CMPB_OFS_REF) | (PADDR == `CMPB_OFS_IRQF);

  // Status mirror, unimplemented bits zero
  always_comb
  begin
    stat_word = `CMPB_RST_VAL;
    stat_word[`CMPB_STAT_IDLE] = st_r.idle_stop;
    stat_word[`CMPB_STAT_EVT_LO +: NCMP] = evt_bits;
    stat_word[NCMP-1:0] = cmp_eff;
  end

  // ----------------------------------------
  // Next state
  // ----------------------------------------
  always_comb
  begin
    logic [NCMP-1:0] cur_out;
    logic [15:0] wv;
    cur_out = cmp_eff;
    wv = PWDATA[15:0];
    st_nxt = st_r;
    st_nxt.prev = cmp_eff;
    st_nxt.arm_hold = '0;
    // Output bits are live values, not stored
    for (int i = 0; i < NCMP; i++)
    begin
      st_nxt.cmp_enable[i][`CMPB_CON_OUT] = 1'b0;
    end
    // Register writes; sleep and wake never touch them
    if (wr_acc)
    begin
      for (int i = 0; i < NCMP; i++)
      begin
        if (PADDR == `CMPB_OFS_CON1 + 12'(4 * i))
        begin
          st_nxt.cmp_enable[i] = (wv & `CMPB_CON_WMASK) | (st_r.cmp_enable[i] & ~`CMPB_CON_WMASK);
          st_nxt.cmp_enable[i][`CMPB_CON_EVT] = wv[`CMPB_CON_EVT];
          st_nxt.cmp_enable[i][`CMPB_CON_OUT] = 1'b0;
          // Clearing a set event starts a one-cycle rearm
          if (evt_bits[i] & ~wv[`CMPB_CON_EVT])
            st_nxt.arm_hold[i] = 1'b1;
          if (wv[`CMPB_CON_EVT])
            st_nxt.irq_flag = 1'b1;
        end
      end
      if (PADDR == `CMPB_OFS_STAT)
        st_nxt.idle_stop = wv[`CMPB_STAT_IDLE];
      if (PADDR == `CMPB_OFS_REF)
        st_nxt.refc = wv & `CMPB_REF_WMASK;
      if (PADDR == `CMPB_OFS_IRQF)
        st_nxt.irq_flag = wv[0];
    end
    // Snapshot on reads of status or control
    if (rd_acc && ((PADDR == `CMPB_OFS_STAT) || (PADDR == `CMPB_OFS_CON1) ||
        (PADDR == `CMPB_OFS_CON2) || (PADDR == `CMPB_OFS_CON3)))
      st_nxt.snap = cur_out;
    // Hardware sets win over software clears
    for (int i = 0; i < NCMP; i++)
    begin
      if (evt_hit[i])
        st_nxt.cmp_enable[i][`CMPB_CON_EVT] = 1'b1;
    end
    if (|(cmp_eff ^ st_r.snap))
      st_nxt.irq_flag = 1'b1;
    // Read data, registered
    st_nxt.rdata = '0;
    if (PSEL & ~PENABLE & ~PWRITE)
    begin
      case (PADDR)
        `CMPB_OFS_STAT: st_nxt.rdata = {16'h0000, stat_word};
        `CMPB_OFS_REF: st_nxt.rdata = {16'h0000, st_r.refc};
        `CMPB_OFS_IRQF: st_nxt.rdata = {31'h00000000, st_r.irq_flag};
        default:
        begin
          for (int i = 0; i < NCMP; i++)
          begin
            if (PADDR == `CMPB_OFS_CON1 + 12'(4 * i))
            begin
              st_nxt.rdata = {16'h0000, st_r.cmp_enable[i]};
              st_nxt.rdata[`CMPB_CON_OUT] = cmp_eff[i];
            end
          end
        end
      endcase
    end
    // Idle-stop gates the request; sleep keeps it and wakes
    st_nxt.irq = st_nxt.irq_flag & IRQ_ENABLE & ~(IDLE_MODE & st_r.idle_stop);
    st_nxt.wake = st_nxt.irq_flag & IRQ_ENABLE & SLEEP_MODE;
  end

  // Synchronous reset to all-zero registers
  always_ff @(posedge SYS_CLK)
  begin
    if (SYS_RST)
      st_r <= '0;
    else if (CLK_EN)
      st_r <= st_nxt;
  end

  // ----------------------------------------
  // Outputs
  // ----------------------------------------
  assign PREADY = 1'b1;
  assign PSLVERR = PSEL & PENABLE & ~hit;
  assign PRDATA = st_r.rdata;
  assign COMPARATOR_IRQ_FLAG = st_r.irq_flag;
  assign IRQ_REQ = st_r.irq;
  assign WAKE_REQ = st_r.wake;
  assign CMP_OUT = cmp_eff;
  // Ladder independent of comparator enables
  always_comb
  begin
    LADDER.enable = st_r.refc[`CMPB_REF_EN];
    LADDER.pin_drive = st_r.refc[`CMPB_REF_OE];
    LADDER.source_pick = st_r.refc[`CMPB_REF_SRC];
    LADDER.supply_pick = st_r.refc[`CMPB_REF_SS];
    LADDER.range = st_r.refc[`CMPB_REF_RNG];
    LADDER.tap = st_r.refc[3:0];
    LADDER.bandgap_pick = st_r.refc[9:8];
  end
  generate
    for (gi = 0; gi < NCMP; gi++)
    begin : g_ana
      assign CMP_ANA[gi].enable = st_r.cmp_enable[gi][`CMPB_CON_EN];
      assign CMP_ANA[gi].out_en = st_r.cmp_enable[gi][14];
      assign CMP_ANA[gi].low_power = st_r.cmp_enable[gi][12];
      assign CMP_ANA[gi].ref_pick = st_r.cmp_enable[gi][4];
      assign CMP_ANA[gi].chan = st_r.cmp_enable[gi][1:0];
    end
  endgenerate

  // ----------------------------------------
  // Assertions
  // ----------------------------------------
  property p_flag_on_change;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (CLK_EN && |(cmp_eff ^ st_r.snap)) |=> COMPARATOR_IRQ_FLAG;
  endproperty
  a_flag_on_change: assert property (p_flag_on_change) else $error("flag missed change");
  property p_flag_sticky;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (COMPARATOR_IRQ_FLAG && !wr_acc) |=> COMPARATOR_IRQ_FLAG;
  endproperty
  a_flag_sticky: assert property (p_flag_sticky) else $error("flag dropped");
  property p_evt_sticky;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (evt_bits[0] && !wr_acc) |=> evt_bits[0];
  endproperty
  a_evt_sticky: assert property (p_evt_sticky) else $error("event dropped");
  property p_disabled_quiet;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (!en_bits[0] && !evt_bits[0] && !(wr_acc && PADDR == `CMPB_OFS_CON1)) |=> !evt_bits[0];
  endproperty
  a_disabled_quiet: assert property (p_disabled_quiet) else $error("disabled event");
  property p_idle_gate;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (CLK_EN && IDLE_MODE && st_r.idle_stop) |=> !IRQ_REQ;
  endproperty
  a_idle_gate: assert property (p_idle_gate) else $error("irq in idle stop");
  property p_sw_set;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (CLK_EN && wr_acc && PADDR == `CMPB_OFS_IRQF && PWDATA[0]) |=> COMPARATOR_IRQ_FLAG;
  endproperty
  a_sw_set: assert property (p_sw_set) else $error("soft set lost");
  property p_ladder_follow;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (CLK_EN && wr_acc && PADDR == `CMPB_OFS_REF) |=> (LADDER.tap == $past(PWDATA[3:0]));
  endproperty
  a_ladder_follow: assert property (p_ladder_follow) else $error("tap not written");
  property p_mirror;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (CLK_EN && PSEL && !PENABLE && !PWRITE && PADDR == `CMPB_OFS_STAT) |=>
        (PRDATA[`CMPB_STAT_EVT_LO +: NCMP] == $past(evt_bits) &&
        PRDATA[NCMP-1:0] == $past(cmp_eff));
  endproperty
  a_mirror: assert property (p_mirror) else $error("mirror wrong");

  // ----------------------------------------
  // Reset, flag, event, interrupt, sleep and ladder assertions
  // ----------------------------------------
  // Reset checks carry no disable so the reset edge itself is watched
  property p_rst_con;
    @(posedge SYS_CLK)
      SYS_RST |=> (en_bits == '0);
  endproperty
  a_rst_con: assert property (p_rst_con) else $error("comparator left on");
  property p_rst_ref;
    @(posedge SYS_CLK)
      SYS_RST |=> ({LADDER.enable, LADDER.pin_drive, LADDER.range, LADDER.tap} == 7'h00);
  endproperty
  a_rst_ref: assert property (p_rst_ref) else $error("ladder not cleared");
  property p_rst_read;
    @(posedge SYS_CLK)
      SYS_RST |=> (PRDATA == 32'h0000_0000 && !COMPARATOR_IRQ_FLAG &&
        stat_word == 16'h0000);
  endproperty
  a_rst_read: assert property (p_rst_read) else $error("nonzero after reset");
  property p_quiet_flag;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (CLK_EN && !COMPARATOR_IRQ_FLAG && !wr_acc && cmp_eff == st_r.snap) |=> !COMPARATOR_IRQ_FLAG;
  endproperty
  a_quiet_flag: assert property (p_quiet_flag) else $error("flag without change");
  property p_snap_take;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (CLK_EN && rd_acc && PADDR == `CMPB_OFS_STAT) |=> (st_r.snap == $past(cmp_eff));
  endproperty
  a_snap_take: assert property (p_snap_take) else $error("snapshot missed");
  property p_evt_hold_off;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (!evt_bits[0] && !evt_hit[0] && !(wr_acc && PADDR == `CMPB_OFS_CON1)) |=> !evt_bits[0];
  endproperty
  a_evt_hold_off: assert property (p_evt_hold_off) else $error("event from nowhere");
  property p_rearm;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (CLK_EN && wr_acc && PADDR == `CMPB_OFS_CON1 && evt_bits[0] && !PWDATA[`CMPB_CON_EVT]) |=>
        !evt_hit[0];
  endproperty
  a_rearm: assert property (p_rearm) else $error("rearmed too early");
  property p_irq_normal;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (CLK_EN && !IDLE_MODE && IRQ_ENABLE) |=> (IRQ_REQ == COMPARATOR_IRQ_FLAG);
  endproperty
  a_irq_normal: assert property (p_irq_normal) else $error("irq not following flag");
  property p_irq_masked;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (CLK_EN && !IRQ_ENABLE) |=> (!IRQ_REQ && !WAKE_REQ);
  endproperty
  a_irq_masked: assert property (p_irq_masked) else $error("masked irq raised");
  property p_wake;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (CLK_EN && SLEEP_MODE && IRQ_ENABLE) |=> (WAKE_REQ == COMPARATOR_IRQ_FLAG);
  endproperty
  a_wake: assert property (p_wake) else $error("wake not following flag");
  property p_sleep_con;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (SLEEP_MODE && !wr_acc) |=> $stable(CMP_ANA);
  endproperty
  a_sleep_con: assert property (p_sleep_con) else $error("control changed in sleep");
  property p_sleep_ref;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (SLEEP_MODE && !wr_acc) |=> $stable(LADDER);
  endproperty
  a_sleep_ref: assert property (p_sleep_ref) else $error("ladder changed in sleep");
  property p_ladder_bits;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (CLK_EN && wr_acc && PADDR == `CMPB_OFS_REF) |=>
        (LADDER.enable == $past(PWDATA[`CMPB_REF_EN]) &&
        LADDER.pin_drive == $past(PWDATA[`CMPB_REF_OE]));
  endproperty
  a_ladder_bits: assert property (p_ladder_bits) else $error("ladder enable wrong");
  property p_ladder_pick;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (CLK_EN && wr_acc && PADDR == `CMPB_OFS_REF) |=>
        (LADDER.source_pick == $past(PWDATA[`CMPB_REF_SRC]) &&
        LADDER.supply_pick == $past(PWDATA[`CMPB_REF_SS]) &&
        LADDER.range == $past(PWDATA[`CMPB_REF_RNG]));
  endproperty
  a_ladder_pick: assert property (p_ladder_pick) else $error("ladder pick wrong");
  property p_stat_zero;
    @(posedge SYS_CLK) disable iff (SYS_RST)
      (CLK_EN && PSEL && !PENABLE && !PWRITE && PADDR == `CMPB_OFS_STAT) |=>
        (PRDATA[31:16] == 16'h0000 && PRDATA[14:11] == 4'h0);
  endproperty
  a_stat_zero: assert property (p_stat_zero) else $error("unused status bits set");
endmodule // cmpb_top

/* File: tb/cmpb_testbench.sv */
`timescale 1ns/1ps
`include "cmpb_defs.svh"
`define CHK(a, b) begin n_checks++; if ((a) !== (b)) begin n_errors++; \
  $display("CHECK FAILED t=%0t got=%h exp=%h", $time, (a), (b)); end end
module testbench;
  import cmpb_pkg::*;
  logic sys_clk;
  logic sys_rst;
  logic clk_en;
  logic psel, penable, pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rd;
  logic pready, pslverr, err;
  logic [2:0] cmp_raw, cmp_out;
  logic idle_mode, sleep_mode, irq_enable;
  logic irq_flag, irq_req, wake_req;
  cmpb_ladder_t ladder;
  cmpb_ana_t [2:0] cmp_ana;
  int n_errors = 0;
  int n_checks = 0;
  logic [31:0] d;
  logic [11:0] addrs [6];

  cmpb_top #(.NCMP(3)) uut (.SYS_CLK(sys_clk), .SYS_RST(sys_rst), .CLK_EN(clk_en),
    .PSEL(psel), .PENABLE(penable), .PWRITE(pwrite), .PADDR(paddr), .PWDATA(pwdata),
    .PRDATA(prdata), .PREADY(pready), .PSLVERR(pslverr), .CMP_RAW(cmp_raw),
    .IDLE_MODE(idle_mode), .SLEEP_MODE(sleep_mode), .IRQ_ENABLE(irq_enable),
    .COMPARATOR_IRQ_FLAG(irq_flag), .IRQ_REQ(irq_req), .WAKE_REQ(wake_req),
    .CMP_OUT(cmp_out), .LADDER(ladder), .CMP_ANA(cmp_ana));

  // ----------------------------------------
  // Clock and hang guard
  // ----------------------------------------
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // Cuts a hung run short
  initial
  begin
    #2000000;
    n_errors++;
    finish_test();
  end

  // ----------------------------------------
  // Bench tasks and expectations
  // ----------------------------------------
  task automatic finish_test();
    if (n_errors == 0 && n_checks > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  // One APB transfer; request held until pready seen high
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] wd);
    int i;
    @(posedge sys_clk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= wd;
    @(posedge sys_clk);
    penable <= 1'b1;
    for (i = 0; i < 20; i++)
    begin
      @(posedge sys_clk);
      if (pready === 1'b1)
        break;
    end
    if (i == 20)
    begin
      n_errors++;
      finish_test();
    end
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    // Writes land on the access edge; let them settle before callers look
    @(posedge sys_clk);
  endtask

  // Bounded wait for the interrupt flag
  task automatic wait_flag();
    int i;
    for (i = 0; i < 10 && irq_flag !== 1'b1; i++)
      @(posedge sys_clk);
    `CHK(irq_flag, 1'b1)
  endtask

  function automatic cmpb_ladder_t ladder_exp(input logic [31:0] v);
    return '{v[7], v[6], v[10], v[4], v[5], v[3:0], v[9:8]};
  endfunction

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial
  begin
    sys_rst = 1'b1;
    clk_en = 1'b1;
    {psel, penable, pwrite} = 3'b000;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    cmp_raw = 3'h0;
    {idle_mode, sleep_mode, irq_enable} = 3'b001;
    addrs = '{`CMPB_OFS_STAT, `CMPB_OFS_CON1, `CMPB_OFS_CON2, `CMPB_OFS_CON3,
      `CMPB_OFS_REF, `CMPB_OFS_IRQF};
    void'($urandom(87));
    repeat (20) @(posedge sys_clk);
    sys_rst <= 1'b0;
    // Every register zero after reset
    foreach (addrs[k])
    begin
      apb(1'b0, addrs[k], 32'h0);
      `CHK(rd, 32'h0000_0000)
    end
    `CHK(ladder, cmpb_ladder_t'(0))
    `CHK(cmp_ana[0].enable, 1'b0)
    // Random ladder settings, corners first
    for (int n = 0; n < 10; n++)
    begin
      d = (n == 0) ? 32'hffff_ffff : (n == 1) ? 32'h0 : $urandom();
      apb(1'b1, `CMPB_OFS_REF, d);
      `CHK(ladder, ladder_exp(d))
      apb(1'b0, `CMPB_OFS_REF, 32'h0);
      `CHK(rd, d & 32'h0000_07ff)
    end
    // Unmapped address refused
    apb(1'b1, 12'h018, 32'hffff_ffff);
    `CHK(err, 1'b1)
    apb(1'b0, 12'h018, 32'h0);
    `CHK(rd, 32'h0000_0000)
    // Disabled comparator: no event on change
    cmp_raw <= 3'b010;
    repeat (6) @(posedge sys_clk);
    apb(1'b0, `CMPB_OFS_STAT, 32'h0);
    `CHK(rd[9], 1'b0)
    `CHK(irq_flag, 1'b0)
    // Enable comparator 1 on both edges, then change its input
    apb(1'b1, `CMPB_OFS_CON1, 32'h0000_80c0);
    `CHK(cmp_ana[0].enable, 1'b1)
    cmp_raw <= 3'b011;
    wait_flag();
    apb(1'b0, `CMPB_OFS_STAT, 32'h0);
    `CHK(rd[10:8], 3'b001)
    `CHK(rd[0], 1'b1)
    `CHK(cmp_out, 3'b001)
    repeat (20) @(posedge sys_clk);
    `CHK(irq_flag, 1'b1)
    `CHK(irq_req, 1'b1)
    // Second edge is blocked while the event stands
    cmp_raw <= 3'b010;
    repeat (6) @(posedge sys_clk);
    apb(1'b0, `CMPB_OFS_CON1, 32'h0);
    `CHK(rd[9:8], 2'b10)
    // Sleep wake, then idle with the stop bit
    sleep_mode <= 1'b1;
    repeat (3) @(posedge sys_clk);
    `CHK(wake_req, 1'b1)
    sleep_mode <= 1'b0;
    apb(1'b0, `CMPB_OFS_REF, 32'h0);
    `CHK(rd, d & 32'h0000_07ff)
    apb(1'b0, `CMPB_OFS_CON1, 32'h0);
    `CHK(rd[15], 1'b1)
    apb(1'b1, `CMPB_OFS_STAT, 32'h0000_8000);
    idle_mode <= 1'b1;
    repeat (3) @(posedge sys_clk);
    `CHK(irq_req, 1'b0)
    idle_mode <= 1'b0;
    // Software clears event and flag
    apb(1'b1, `CMPB_OFS_CON1, 32'h0000_80c0);
    apb(1'b0, `CMPB_OFS_STAT, 32'h0);
    `CHK(rd[8], 1'b0)
    `CHK(rd[15], 1'b1)
    apb(1'b1, `CMPB_OFS_IRQF, 32'h0);
    repeat (2) @(posedge sys_clk);
    `CHK(irq_flag, 1'b0)
    // Software-raised interrupt
    apb(1'b1, `CMPB_OFS_IRQF, 32'h1);
    repeat (2) @(posedge sys_clk);
    `CHK(irq_flag, 1'b1)
    `CHK(irq_req, 1'b1)
    // Falling-only event on comparator 2 ignores a rise
    cmp_raw <= 3'b000;
    repeat (6) @(posedge sys_clk);
    apb(1'b1, `CMPB_OFS_CON2, 32'h0000_8080);
    cmp_raw <= 3'b010;
    repeat (6) @(posedge sys_clk);
    apb(1'b0, `CMPB_OFS_STAT, 32'h0);
    `CHK(rd[9], 1'b0)
    `CHK(rd[1], 1'b1)
    cmp_raw <= 3'b000;
    repeat (6) @(posedge sys_clk);
    apb(1'b0, `CMPB_OFS_STAT, 32'h0);
    `CHK(rd[10:8], 3'b010)
    // Reset mid-run clears control
    sys_rst <= 1'b1;
    repeat (2) @(posedge sys_clk);
    sys_rst <= 1'b0;
    apb(1'b0, `CMPB_OFS_CON1, 32'h0);
    `CHK(rd[15], 1'b0)
    `CHK(ladder, cmpb_ladder_t'(0))
    finish_test();
  end
endmodule // testbench
